/* rtl/arpwm_counter.sv */
// up counter with auto-reload and a clock-enable prescaler
// assumes one system clock; counter clock is an enable pulse
`timescale 1ns/1ps
module arpwm_counter
	import arpwm_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic        i_run,
	input  wire logic [15:0] i_presc,
	input  wire logic [11:0] i_reload,
	output logic      [11:0] o_count,
	output logic             o_wrap
);
	logic [15:0] div_q;
	logic [15:0] div_d;
	logic [11:0] cnt_q;
	logic [11:0] cnt_d;
	logic        tick;
	logic        wrap_q;

	// divider: one tick every presc+1 system clocks
	assign tick  = i_run && (div_q == i_presc);
	assign div_d = (!i_run || tick) ? 16'h0000 : div_q + 16'h0001;
	// reload after the top value, else step up
	assign cnt_d = !tick ? cnt_q :
		(cnt_q == ARPWM_CNT_MAX) ? i_reload : cnt_q + 12'h001;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			div_q  <= ARPWM_PRESC_RST;
			cnt_q  <= ARPWM_RELOAD_RST;
			wrap_q <= 1'b0;
		end else begin
			div_q  <= div_d;
			cnt_q  <= cnt_d;
			wrap_q <= tick && (cnt_q == ARPWM_CNT_MAX);
		end
	end

	assign o_count = cnt_q;
	assign o_wrap  = wrap_q;
endmodule // arpwm_counter

/* rtl/arpwm_pkg.sv */
// package for the auto-reload pwm generator: register map and constants
// assumes an axi4-lite master with 32-bit data on the same clock
// Operation
// - four pwm channels 0..3, each configured on its own; 1..3 optional
// - pwm period set by counter clock period and the reload value
// - reload register holds a 12-bit value from 0x000 to 0xFFF
// - polarity 0: low when counter above duty, high otherwise
// - polarity 1: high when counter above duty, low otherwise
// - each channel holds a 12-bit duty compare value
package arpwm_pkg;
	localparam int          ARPWM_CNT_W        = 12;
	localparam int          ARPWM_NUM_CH       = 4;
	localparam logic [11:0] ARPWM_CNT_MAX      = 12'hFFF;
	localparam logic [11:0] ARPWM_RELOAD_RST   = 12'h000;
	localparam logic [11:0] ARPWM_DUTY_RST     = 12'h000;
	localparam logic [15:0] ARPWM_PRESC_RST    = 16'h0000;
	// byte offsets of the register map
	localparam logic [7:0]  ARPWM_OFS_CTRL     = 8'h00;
	localparam logic [7:0]  ARPWM_OFS_RELOAD   = 8'h04;
	localparam logic [7:0]  ARPWM_OFS_PRESC    = 8'h08;
	localparam logic [7:0]  ARPWM_OFS_COUNT    = 8'h0C;
	localparam logic [7:0]  ARPWM_OFS_DUTY0    = 8'h10;
	localparam logic [7:0]  ARPWM_OFS_POL      = 8'h20;
	localparam logic [7:0]  ARPWM_OFS_STATUS   = 8'h24;
	// control register fields and bus response codes
	localparam int          ARPWM_CTRL_RUN_BIT = 0;
	localparam int          ARPWM_CTRL_EN_LSB  = 4;
	localparam logic [1:0]  ARPWM_RESP_OKAY    = 2'h0;
	localparam logic [1:0]  ARPWM_RESP_SLVERR  = 2'h2;
endpackage

/* rtl/arpwm_top.sv */
// auto-reload pwm generator with four channels and an axi4-lite slave
// assumes the master keeps one write and one read in flight at a time
`timescale 1ns/1ps
module arpwm_top
	import arpwm_pkg::*;
#(
	parameter int NUM_CH = ARPWM_NUM_CH
)(
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	input  wire logic [7:0]        i_s_axi_awaddr,
	input  wire logic              i_s_axi_awvalid,
	output logic                   o_s_axi_awready,
	input  wire logic [31:0]       i_s_axi_wdata,
	input  wire logic [3:0]        i_s_axi_wstrb,
	input  wire logic              i_s_axi_wvalid,
	output logic                   o_s_axi_wready,
	output logic [1:0]             o_s_axi_bresp,
	output logic                   o_s_axi_bvalid,
	input  wire logic              i_s_axi_bready,
	input  wire logic [7:0]        i_s_axi_araddr,
	input  wire logic              i_s_axi_arvalid,
	output logic                   o_s_axi_arready,
	output logic [31:0]            o_s_axi_rdata,
	output logic [1:0]             o_s_axi_rresp,
	output logic                   o_s_axi_rvalid,
	input  wire logic              i_s_axi_rready,
	output logic [NUM_CH-1:0]      o_pwm_channel_output
);
	// bus channel state: write address and data are latched separately
	logic        aw_full_q;
	logic        w_full_q;
	logic [7:0]  aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        bvalid_q;
	logic [1:0]  bresp_q;
	logic        rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0]  rresp_q;
	logic        wr_go;
	logic        wr_hit;
	logic        rd_hit;
	logic [31:0] rd_val;
	logic        wr_done;
	logic [31:0] wr_old;
	logic [31:0] wr_new;

	// configuration, counter and pwm output state
	logic              run_q;
	logic [NUM_CH-1:0] chan_en_q;
	logic [NUM_CH-1:0] pol_q;
	logic [11:0]       reload_value_reg_q;
	logic [15:0]       presc_q;
	logic [11:0]       duty_q [NUM_CH];
	logic [31:0]       duty_new [NUM_CH];
	logic [NUM_CH-1:0] pwm_q;
	logic [NUM_CH-1:0] pwm_d;
	logic [11:0]       count;
	logic              wrap;
	logic              wrap_seen_q;

	// merge byte lanes of a write into an old word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (st[b])
				r[b*8 +: 8] = nw[b*8 +: 8];
		end
		return r;
	endfunction

	// true when an address hits the map
	function automatic logic mapped(input logic [7:0] a);
		logic ok;
		ok = (a == ARPWM_OFS_CTRL) || (a == ARPWM_OFS_RELOAD) ||
			(a == ARPWM_OFS_PRESC) || (a == ARPWM_OFS_COUNT) ||
			(a == ARPWM_OFS_POL) || (a == ARPWM_OFS_STATUS) ||
			((a >= ARPWM_OFS_DUTY0) &&
			 (a < ARPWM_OFS_DUTY0 + 8'(4*NUM_CH)) && (a[1:0] == 2'h0));
		return ok;
	endfunction

	// a write goes once both halves are held and no response waits
	assign wr_go  = aw_full_q && w_full_q && !bvalid_q;
	// both halves stay held, so ready stays low, until the response retires
	assign wr_done = bvalid_q && i_s_axi_bready;
	// old word at the write address with the written byte lanes merged in
	assign wr_old  = (aw_addr_q == ARPWM_OFS_CTRL) ?
		{20'h00000, 8'(chan_en_q), 3'h0, run_q} :
		(aw_addr_q == ARPWM_OFS_RELOAD) ? {20'h00000, reload_value_reg_q} :
		(aw_addr_q == ARPWM_OFS_PRESC) ? {16'h0000, presc_q} : 32'h00000000;
	assign wr_new  = merge(wr_old, w_data_q, w_strb_q);
	assign wr_hit = mapped(aw_addr_q);
	assign rd_hit = mapped(i_s_axi_araddr);

	// write address and data may arrive in either order
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			aw_full_q <= 1'b0;
			w_full_q  <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q  <= 32'h00000000;
			w_strb_q  <= 4'h0;
		end else begin
			if (i_s_axi_awvalid && !aw_full_q) begin
				aw_full_q <= 1'b1;
				aw_addr_q <= i_s_axi_awaddr;
			end else if (wr_done) begin
				aw_full_q <= 1'b0;
			end
			if (i_s_axi_wvalid && !w_full_q) begin
				w_full_q <= 1'b1;
				w_data_q <= i_s_axi_wdata;
				w_strb_q <= i_s_axi_wstrb;
			end else if (wr_done) begin
				w_full_q <= 1'b0;
			end
		end
	end

	// write response; unmapped addresses answer slverr
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			bvalid_q <= 1'b0;
			bresp_q  <= ARPWM_RESP_OKAY;
		end else if (wr_go) begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_hit ? ARPWM_RESP_OKAY : ARPWM_RESP_SLVERR;
		end else if (i_s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// register writes; each channel has its own duty and enable
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			run_q              <= 1'b0;
			chan_en_q          <= '0;
			pol_q              <= '0;
			reload_value_reg_q <= ARPWM_RELOAD_RST;
			presc_q            <= ARPWM_PRESC_RST;
		end else if (wr_go) begin
			case (aw_addr_q)
				ARPWM_OFS_CTRL: begin
					chan_en_q <= wr_new[ARPWM_CTRL_EN_LSB +: NUM_CH];
					run_q     <= wr_new[ARPWM_CTRL_RUN_BIT];
				end
				ARPWM_OFS_RELOAD: begin
					reload_value_reg_q <= wr_new[11:0];
				end
				ARPWM_OFS_PRESC: begin
					presc_q <= wr_new[15:0];
				end
				ARPWM_OFS_POL: begin
					if (w_strb_q[0])
						pol_q <= w_data_q[NUM_CH-1:0];
				end
				default: begin
				end
			endcase
		end
	end

	// duty registers, one per channel
	generate
		for (genvar c = 0; c < NUM_CH; c++) begin : g_duty
			always_ff @(posedge i_clk) begin
				if (i_rst)
					duty_q[c] <= ARPWM_DUTY_RST;
				else if (wr_go && aw_addr_q == ARPWM_OFS_DUTY0 + 8'(4*c))
					duty_q[c] <= duty_new[c][11:0];
			end
			// old duty word with the written byte lanes merged in
			assign duty_new[c] = merge({20'h00000, duty_q[c]}, w_data_q,
				w_strb_q);
			// compare and polarity; disabled channels idle at polarity
			assign pwm_d[c] = !(run_q && chan_en_q[c]) ? pol_q[c] :
				((count > duty_q[c]) ? pol_q[c] : !pol_q[c]);
		end
	endgenerate

	// read data selection
	always_comb begin
		rd_val = 32'h00000000;
		case (i_s_axi_araddr)
			ARPWM_OFS_CTRL:   rd_val = {20'h0, 8'(chan_en_q), 3'h0, run_q};
			ARPWM_OFS_RELOAD: rd_val = {20'h0, reload_value_reg_q};
			ARPWM_OFS_PRESC:  rd_val = {16'h0, presc_q};
			ARPWM_OFS_COUNT:  rd_val = {20'h0, count};
			ARPWM_OFS_POL:    rd_val = {28'h0, 4'(pol_q)};
			ARPWM_OFS_STATUS: rd_val = {23'h0, wrap_seen_q, 4'h0, 4'(pwm_q)};
			default: begin
				for (int c = 0; c < NUM_CH; c++) begin
					if (i_s_axi_araddr == ARPWM_OFS_DUTY0 + 8'(4*c))
						rd_val = {20'h0, duty_q[c]};
				end
			end
		endcase
	end

	// read answer one cycle after the address is taken
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			rvalid_q <= 1'b0;
			rdata_q  <= 32'h00000000;
			rresp_q  <= ARPWM_RESP_OKAY;
		end else if (i_s_axi_arvalid && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rdata_q  <= rd_hit ? rd_val : 32'h00000000;
			rresp_q  <= rd_hit ? ARPWM_RESP_OKAY : ARPWM_RESP_SLVERR;
		end else if (i_s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// shared counter for all channels
	arpwm_counter u_counter (
		.i_clk    (i_clk),
		.i_rst    (i_rst),
		.i_run    (run_q),
		.i_presc  (presc_q),
		.i_reload (reload_value_reg_q),
		.o_count  (count),
		.o_wrap   (wrap)
	);

	// sticky wrap flag, cleared by a status write with byte lane 1 strobed; a wrap wins the clear
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wrap_seen_q <= 1'b0;
			pwm_q       <= '0;
		end else begin
			wrap_seen_q <= wrap || (wrap_seen_q &&
				!(wr_go && aw_addr_q == ARPWM_OFS_STATUS && w_strb_q[1]));
			pwm_q       <= pwm_d;
		end
	end

	assign o_s_axi_awready      = !aw_full_q;
	assign o_s_axi_wready       = !w_full_q;
	assign o_s_axi_bvalid       = bvalid_q;
	assign o_s_axi_bresp        = bresp_q;
	assign o_s_axi_arready      = !rvalid_q;
	assign o_s_axi_rvalid       = rvalid_q;
	assign o_s_axi_rdata        = rdata_q;
	assign o_s_axi_rresp        = rresp_q;
	assign o_pwm_channel_output = pwm_q;
endmodule // arpwm_top

/* testbench/arpwm_top_asserts.sv */
// checker for the pwm generator bus handshakes and outputs
// assumes it is bound onto arpwm_top and sees only its ports
`timescale 1ns/1ps
module arpwm_top_asserts #(
	parameter int NUM_CH = 4
)(
	input wire logic              i_clk,
	input wire logic              i_rst,
	input wire logic              i_s_axi_awvalid,
	input wire logic              o_s_axi_awready,
	input wire logic              i_s_axi_wvalid,
	input wire logic              o_s_axi_wready,
	input wire logic [1:0]        o_s_axi_bresp,
	input wire logic              o_s_axi_bvalid,
	input wire logic              i_s_axi_bready,
	input wire logic              i_s_axi_arvalid,
	input wire logic              o_s_axi_arready,
	input wire logic [31:0]       o_s_axi_rdata,
	input wire logic              o_s_axi_rvalid,
	input wire logic              i_s_axi_rready,
	input wire logic [NUM_CH-1:0] o_pwm_channel_output
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);
	// after reset the pins sit low and the bus is idle
	rst_idle_a: assert property ($fell(i_rst) |->
		o_pwm_channel_output == '0 && !o_s_axi_bvalid && !o_s_axi_rvalid)
		else $error("outputs not idle after reset");
	// a response must not change or vanish while it waits
	bresp_hold_a: assert property (o_s_axi_bvalid && !i_s_axi_bready
		|=> o_s_axi_bvalid && $stable(o_s_axi_bresp))
		else $error("write response dropped");
	write_answer_a: assert property (i_s_axi_awvalid && o_s_axi_awready
		&& i_s_axi_wvalid && o_s_axi_wready |-> ##[1:3] o_s_axi_bvalid)
		else $error("write not answered");
	write_block_a: assert property (o_s_axi_bvalid
		|-> !o_s_axi_awready && !o_s_axi_wready)
		else $error("write taken while answering");
	read_answer_a: assert property (i_s_axi_arvalid && o_s_axi_arready
		|=> o_s_axi_rvalid)
		else $error("read not answered");
	rdata_hold_a: assert property (o_s_axi_rvalid && !i_s_axi_rready
		|=> o_s_axi_rvalid && $stable(o_s_axi_rdata))
		else $error("read data changed while waiting");
	read_block_a: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
		else $error("read taken while answering");
	read_retire_a: assert property (o_s_axi_rvalid && i_s_axi_rready
		|=> !o_s_axi_rvalid)
		else $error("read response not retired");
endmodule // arpwm_top_asserts

bind arpwm_top arpwm_top_asserts #(.NUM_CH(NUM_CH)) i_arpwm_top_asserts (
	.i_clk, .i_rst, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wvalid,
	.o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready,
	.i_s_axi_arvalid, .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rvalid,
	.i_s_axi_rready, .o_pwm_channel_output);

/* testbench/tb_arpwm_top.sv */
// self-checking bench for the pwm generator through its axi4-lite port
// assumes the design answers every bus request before the watchdog fires
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
	$display("Error %s expected %h seen %h", nm, e, g); end end
module tb_arpwm_top;
	import arpwm_pkg::*;
	logic        i_clk, i_rst, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready;
	logic        i_s_axi_arvalid, i_s_axi_rready, o_s_axi_awready;
	logic        o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready;
	logic        o_s_axi_rvalid;
	logic [7:0]  i_s_axi_awaddr, i_s_axi_araddr;
	logic [31:0] i_s_axi_wdata, o_s_axi_rdata;
	logic [3:0]  i_s_axi_wstrb, o_pwm_channel_output;
	logic [1:0]  o_s_axi_bresp, o_s_axi_rresp;
	logic [7:0]  hi [4];
	int          err_total = 0;
	int          compares = 0;
	arpwm_top i_arpwm_top (
		.i_clk                (i_clk),
		.i_rst                (i_rst),
		.i_s_axi_awaddr       (i_s_axi_awaddr),
		.i_s_axi_awvalid      (i_s_axi_awvalid),
		.o_s_axi_awready      (o_s_axi_awready),
		.i_s_axi_wdata        (i_s_axi_wdata),
		.i_s_axi_wstrb        (i_s_axi_wstrb),
		.i_s_axi_wvalid       (i_s_axi_wvalid),
		.o_s_axi_wready       (o_s_axi_wready),
		.o_s_axi_bresp        (o_s_axi_bresp),
		.o_s_axi_bvalid       (o_s_axi_bvalid),
		.i_s_axi_bready       (i_s_axi_bready),
		.i_s_axi_araddr       (i_s_axi_araddr),
		.i_s_axi_arvalid      (i_s_axi_arvalid),
		.o_s_axi_arready      (o_s_axi_arready),
		.o_s_axi_rdata        (o_s_axi_rdata),
		.o_s_axi_rresp        (o_s_axi_rresp),
		.o_s_axi_rvalid       (o_s_axi_rvalid),
		.i_s_axi_rready       (i_s_axi_rready),
		.o_pwm_channel_output (o_pwm_channel_output)
	);
	initial begin
		i_clk = 1'h0;
		forever #5 i_clk = ~i_clk;
	end
	// write one word; address and data are offered together
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		@(posedge i_clk);
		i_s_axi_awaddr  <= a;
		i_s_axi_wdata   <= d;
		i_s_axi_awvalid <= 1'h1;
		i_s_axi_wvalid  <= 1'h1;
		i_s_axi_bready  <= 1'h1;
		do begin
			@(posedge i_clk);
			if (i_s_axi_awvalid && o_s_axi_awready) i_s_axi_awvalid <= 1'h0;
			if (i_s_axi_wvalid && o_s_axi_wready) i_s_axi_wvalid <= 1'h0;
		end while (o_s_axi_bvalid !== 1'h1);
		i_s_axi_bready <= 1'h0;
		`CHK("bresp", er, o_s_axi_bresp)
	endtask
	// read one word and judge data and response at the taking edge
	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		@(posedge i_clk);
		i_s_axi_araddr  <= a;
		i_s_axi_arvalid <= 1'h1;
		i_s_axi_rready  <= 1'h1;
		do begin
			@(posedge i_clk);
			if (i_s_axi_arvalid && o_s_axi_arready) i_s_axi_arvalid <= 1'h0;
		end while (o_s_axi_rvalid !== 1'h1);
		i_s_axi_rready <= 1'h0;
		`CHK("rdata", ed, o_s_axi_rdata)
		`CHK("rresp", er, o_s_axi_rresp)
	endtask
	// reset values, 12-bit storage and an unmapped place
	task automatic check_regs();
		rd(ARPWM_OFS_RELOAD, 32'h0, ARPWM_RESP_OKAY);
		wr(ARPWM_OFS_RELOAD, 32'hFFFFFFF0, ARPWM_RESP_OKAY);
		rd(ARPWM_OFS_RELOAD, 32'h00000FF0, ARPWM_RESP_OKAY);
		wr(ARPWM_OFS_DUTY0, 32'h00012FF8, ARPWM_RESP_OKAY);
		rd(ARPWM_OFS_DUTY0, 32'h00000FF8, ARPWM_RESP_OKAY);
		wr(8'h40, 32'h1, ARPWM_RESP_SLVERR);
		rd(8'h40, 32'h0, ARPWM_RESP_SLVERR);
	endtask
	// reload 0xFF0 gives a 16-cycle period; duties and polarities differ
	task automatic check_pwm();
		wr(ARPWM_OFS_PRESC, 32'h0, ARPWM_RESP_OKAY);
		wr(ARPWM_OFS_DUTY0 + 8'h04, 32'hFF8, ARPWM_RESP_OKAY);
		wr(ARPWM_OFS_DUTY0 + 8'h08, 32'hFF0, ARPWM_RESP_OKAY);
		wr(ARPWM_OFS_DUTY0 + 8'h0C, 32'hFFF, ARPWM_RESP_OKAY);
		wr(ARPWM_OFS_POL, 32'hA, ARPWM_RESP_OKAY);
		repeat (2) @(posedge i_clk);
		`CHK("idle level", 4'hA, o_pwm_channel_output)
		wr(ARPWM_OFS_CTRL, 32'hF1, ARPWM_RESP_OKAY);
		// counter starts at zero, so let it pass 0xFFF once first
		repeat (4200) @(posedge i_clk);
		for (int c = 0; c < 4; c++) hi[c] = 8'h0;
		for (int n = 0; n < 160; n++) begin
			@(posedge i_clk);
			for (int c = 0; c < 4; c++) hi[c] += o_pwm_channel_output[c];
		end
		`CHK("ch0 high", 8'h5A, hi[0])
		`CHK("ch1 high", 8'h46, hi[1])
		`CHK("ch2 high", 8'h0A, hi[2])
		`CHK("ch3 high", 8'h00, hi[3])
	endtask
	// stop, sticky wrap flag and its lane-qualified clear, slower count
	task automatic check_status();
		wr(ARPWM_OFS_CTRL, 32'h0, ARPWM_RESP_OKAY);
		rd(ARPWM_OFS_STATUS, 32'h10A, ARPWM_RESP_OKAY);
		i_s_axi_wstrb <= 4'h1;
		wr(ARPWM_OFS_STATUS, 32'h0, ARPWM_RESP_OKAY);
		rd(ARPWM_OFS_STATUS, 32'h10A, ARPWM_RESP_OKAY);
		i_s_axi_wstrb <= 4'hF;
		wr(ARPWM_OFS_STATUS, 32'h0, ARPWM_RESP_OKAY);
		rd(ARPWM_OFS_STATUS, 32'h00A, ARPWM_RESP_OKAY);
		wr(ARPWM_OFS_PRESC, 32'h1, ARPWM_RESP_OKAY);
		rd(ARPWM_OFS_PRESC, 32'h1, ARPWM_RESP_OKAY);
		wr(ARPWM_OFS_CTRL, 32'hF1, ARPWM_RESP_OKAY);
		// counter resumes near the top; two periods settle it
		repeat (64) @(posedge i_clk);
		for (int c = 0; c < 4; c++) hi[c] = 8'h0;
		for (int n = 0; n < 320; n++) begin
			@(posedge i_clk);
			for (int c = 0; c < 4; c++) hi[c] += o_pwm_channel_output[c];
		end
		`CHK("ch0 slow", 8'hB4, hi[0])
		`CHK("ch1 slow", 8'h8C, hi[1])
		`CHK("ch2 slow", 8'h14, hi[2])
	endtask
	task automatic test_done();
		if (err_total == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	// the whole run is about 5000 cycles; a hang ends it here
	initial begin
		#200000;
		err_total++;
		test_done();
	end
	initial begin
		{i_rst, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} = 4'hF;
		{i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} = 3'h0;
		{i_s_axi_arvalid, i_s_axi_rready} = 2'h0;
		i_s_axi_awaddr = 8'h0;
		i_s_axi_araddr = 8'h0;
		i_s_axi_wdata  = 32'h0;
		i_s_axi_wstrb  = 4'hF;
		repeat (5) @(posedge i_clk);
		i_rst <= 1'h0;
		check_regs();
		check_pwm();
		check_status();
		test_done();
	end
endmodule // tb_arpwm_top
